// >>> hw/watchdog_interval_timer.sv
`default_nettype none
module watchdog_interval_timer
	import watchdog_pkg::*;
#(
	parameter int INT_RESET_LEN = INT_RESET_STATES,
	parameter int EXT_RESET_LEN = EXT_RESET_STATES
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [19:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic i_word,
	input wire logic [15:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_interval_interrupt,
	output logic o_internal_reset,
	output logic o_reset_output_pin_n
);
	// pulse counters; wide enough for the longest internal reset
	localparam int LEN_W = 10;
	localparam int LEN_MAX = (1 << LEN_W) - 1;
	localparam logic [LEN_W-1:0] INT_LEN = LEN_W'(INT_RESET_LEN);
	localparam logic [LEN_W-1:0] EXT_LEN = LEN_W'(EXT_RESET_LEN);
	localparam logic [LEN_W-1:0] LEN_ZERO = '0;
	localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

	initial begin
		if (INT_RESET_LEN < 1 || INT_RESET_LEN > LEN_MAX) begin
			$error("internal reset length out of range");
		end
		if (EXT_RESET_LEN < 1 || EXT_RESET_LEN > INT_RESET_LEN) begin
			$error("external reset length out of range");
		end
		if (PRESCALE_W < 12) begin
			$error("prescaler too narrow for the slowest clock");
		end
		if (OVERFLOW_BIT > 7 || MODE_BIT > 7 || ENA_BIT > 7 ||
			WRF_BIT > 7 || ROE_BIT > 7 ||
			OVERFLOW_BIT == MODE_BIT || MODE_BIT == ENA_BIT) begin
			$error("control field position out of range");
		end
	end

	// address decode, shared by the write and read paths
	function automatic logic addr_hit(input logic [19:0] a,
		input logic [19:0] reg_addr);
		addr_hit = (a == reg_addr);
	endfunction : addr_hit

	// the upper byte of a word write carries the password
	function automatic logic key_hit(input logic [15:0] d,
		input logic [7:0] key);
		key_hit = (d[15:8] == key);
	endfunction : key_hit

	// both pulse counters stop at zero
	function automatic logic [LEN_W-1:0] count_down(
		input logic [LEN_W-1:0] v);
		count_down = (v == LEN_ZERO) ? LEN_ZERO : v - LEN_ONE;
	endfunction : count_down

	// register fields
	logic [7:0] watchdog_count_reg;
	logic [7:0] watchdog_count_next;
	logic overflow_flag_reg;
	logic timer_mode_select_reg;
	logic counter_enable_reg;
	logic [2:0] clock_select_reg;
	logic watchdog_reset_flag_reg;
	logic reset_output_enable_reg;
	logic overflow_seen_reg;
	logic wrf_seen_reg;

	// reset pulse counters
	logic [LEN_W-1:0] int_cnt_reg;
	logic [LEN_W-1:0] int_cnt_next;
	logic [LEN_W-1:0] ext_cnt_reg;
	logic [LEN_W-1:0] ext_cnt_next;

	// decoded strobes
	logic tick;
	logic count_tick;
	logic count_full;
	logic overflow;
	logic wdog_fire;
	logic blk_rst;
	logic wr_word;
	logic wr_cnt;
	logic wr_tcs;
	logic wr_rcs_clear;
	logic wr_rcs_oe;
	logic rd_tcs;
	logic rd_rcs;
	logic clear_overflow;
	logic clear_wrf;

	// read path
	logic [7:0] timer_control_status;
	logic [7:0] reset_control_status;
	logic [7:0] rdata_next;

	watchdog_prescaler u_prescaler (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_clock_select(clock_select_reg),
		.o_tick(tick)
	);

	// internal reset clears the timer but not the reset status bits
	assign blk_rst = i_srst | o_internal_reset;

	// byte writes never reach a protected register
	assign wr_word = i_wr & i_word;
	assign wr_cnt = wr_word &
		addr_hit(i_addr, TCS_ADDR) &
		key_hit(i_wdata, PASS_CNT);
	assign wr_tcs = wr_word &
		addr_hit(i_addr, TCS_ADDR) &
		key_hit(i_wdata, PASS_TCS);
	assign wr_rcs_clear = wr_word &
		addr_hit(i_addr, RCS_WR_ADDR) &
		key_hit(i_wdata, PASS_TCS) &
		(i_wdata[7:0] == CLEAR_DATA);
	assign wr_rcs_oe = wr_word &
		addr_hit(i_addr, RCS_WR_ADDR) &
		key_hit(i_wdata, PASS_CNT);
	// reads arm the flag clears
	assign rd_tcs = i_rd & addr_hit(i_addr, TCS_ADDR);
	assign rd_rcs = i_rd & addr_hit(i_addr, RCS_RD_ADDR);

	// a counter write swallows the overflow of the same cycle
	assign count_tick = counter_enable_reg & tick;
	assign count_full = (watchdog_count_reg == 8'hFF);
	assign overflow = count_tick & count_full & ~wr_cnt;
	assign wdog_fire = overflow & timer_mode_select_reg &
		counter_enable_reg;

	// flag clears need a read of 1 since the flag was last set
	assign clear_overflow = wr_tcs & overflow_seen_reg &
		~i_wdata[OVERFLOW_BIT];
	assign clear_wrf = wr_rcs_clear & wrf_seen_reg;

	// counter: a write in the same cycle as a tick wins
	always_comb begin
		watchdog_count_next = watchdog_count_reg;
		if (wr_cnt) begin
			watchdog_count_next = i_wdata[7:0];
		end else if (tick) begin
			watchdog_count_next = watchdog_count_reg + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (blk_rst || !counter_enable_reg) begin
			watchdog_count_reg <= CNT_RESET;
		end else begin
			watchdog_count_reg <= watchdog_count_next;
		end
	end

	// mode select
	always_ff @(posedge i_sys_clk) begin
		if (blk_rst) begin
			timer_mode_select_reg <= 1'b0;
		end else if (wr_tcs) begin
			timer_mode_select_reg <= i_wdata[MODE_BIT];
		end
	end

	// counter enable
	always_ff @(posedge i_sys_clk) begin
		if (blk_rst) begin
			counter_enable_reg <= 1'b0;
		end else if (wr_tcs) begin
			counter_enable_reg <= i_wdata[ENA_BIT];
		end
	end

	// clock select; changing it while counting gives one odd period
	always_ff @(posedge i_sys_clk) begin
		if (blk_rst) begin
			clock_select_reg <= CKS_RESET;
		end else if (wr_tcs) begin
			clock_select_reg <= i_wdata[2:0];
		end
	end

	// overflow flag: a set in the same cycle as a clear wins
	always_ff @(posedge i_sys_clk) begin
		if (blk_rst) begin
			overflow_flag_reg <= 1'b0;
		end else if (overflow) begin
			overflow_flag_reg <= 1'b1;
		end else if (clear_overflow) begin
			overflow_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (blk_rst || overflow || clear_overflow) begin
			overflow_seen_reg <= 1'b0;
		end else if (rd_tcs && overflow_flag_reg) begin
			overflow_seen_reg <= 1'b1;
		end
	end

	// reset status: only the pin reset touches these
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			watchdog_reset_flag_reg <= 1'b0;
		end else if (wdog_fire) begin
			watchdog_reset_flag_reg <= 1'b1;
		end else if (clear_wrf) begin
			watchdog_reset_flag_reg <= 1'b0;
		end
	end

	// a fresh firing needs a fresh read before it can be cleared
	always_ff @(posedge i_sys_clk) begin
		if (i_srst || wdog_fire || clear_wrf) begin
			wrf_seen_reg <= 1'b0;
		end else if (rd_rcs && watchdog_reset_flag_reg) begin
			wrf_seen_reg <= 1'b1;
		end
	end

	// an enable write landing in a firing cycle is dropped
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			reset_output_enable_reg <= 1'b0;
		end else if (wr_rcs_oe && !wdog_fire) begin
			reset_output_enable_reg <= i_wdata[ROE_BIT];
		end
	end

	// pulse lengths count down to zero; the pin reset cancels them
	always_comb begin
		int_cnt_next = int_cnt_reg;
		if (wdog_fire) begin
			int_cnt_next = INT_LEN;
		end else begin
			int_cnt_next = count_down(int_cnt_reg);
		end
	end

	always_comb begin
		ext_cnt_next = ext_cnt_reg;
		if (wdog_fire) begin
			ext_cnt_next = reset_output_enable_reg ?
				EXT_LEN : LEN_ZERO;
		end else begin
			ext_cnt_next = count_down(ext_cnt_reg);
		end
	end

	// internal reset length
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			int_cnt_reg <= LEN_ZERO;
		end else begin
			int_cnt_reg <= int_cnt_next;
		end
	end

	// external pin length
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			ext_cnt_reg <= LEN_ZERO;
		end else begin
			ext_cnt_reg <= ext_cnt_next;
		end
	end

	// outputs come straight from the pulse counters
	assign o_internal_reset = (int_cnt_reg != LEN_ZERO);
	assign o_reset_output_pin_n = (ext_cnt_reg == LEN_ZERO);

	// interrupt follows the flag in interval mode
	assign o_interval_interrupt = overflow_flag_reg &
		~timer_mode_select_reg;

	assign timer_control_status = {
		overflow_flag_reg,
		timer_mode_select_reg,
		counter_enable_reg,
		TCS_RSVD,
		clock_select_reg};
	assign reset_control_status = {
		watchdog_reset_flag_reg,
		reset_output_enable_reg,
		RCS_RSVD};

	// unmapped reads return zero, the write-only address among them
	always_comb begin
		case (i_addr)
			TCS_ADDR: rdata_next = timer_control_status;
			CNT_ADDR: rdata_next = watchdog_count_reg;
			RCS_RD_ADDR: rdata_next = reset_control_status;
			default: rdata_next = 8'h00;
		endcase
	end

	// read data holds until the next read
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= rdata_next;
		end
	end
endmodule : watchdog_interval_timer
`default_nettype wire

// >>> hw/watchdog_prescaler.sv
`default_nettype none
module watchdog_prescaler
	import watchdog_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [2:0] i_clock_select,
	output logic o_tick
);
	logic [PRESCALE_W-1:0] div_reg;
	logic [PRESCALE_W-1:0] div_next;

	function automatic logic [PRESCALE_W-1:0] sel_mask(input logic [2:0] s);
		case (s)
			3'h0: sel_mask = 12'h0001;
			3'h1: sel_mask = 12'h001F;
			3'h2: sel_mask = 12'h003F;
			3'h3: sel_mask = 12'h007F;
			3'h4: sel_mask = 12'h00FF;
			3'h5: sel_mask = 12'h01FF;
			3'h6: sel_mask = 12'h07FF;
			default: sel_mask = 12'h0FFF;
		endcase
	endfunction : sel_mask

	assign div_next = div_reg + 12'h001;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_next;
		end
	end

	// one pulse per period of phi/2 .. phi/4096
	assign o_tick = ((div_reg & sel_mask(i_clock_select)) ==
		sel_mask(i_clock_select));
endmodule : watchdog_prescaler
`default_nettype wire

// >>> inc/watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;
	// byte addresses (lower 20 bits)
	localparam logic [19:0] TCS_ADDR = 20'h0_FFF8C;
	localparam logic [19:0] CNT_ADDR = 20'h0_FFF8D;
	localparam logic [19:0] RCS_WR_ADDR = 20'h0_FFF8E;
	localparam logic [19:0] RCS_RD_ADDR = 20'h0_FFF8F;
	localparam logic [7:0] PASS_CNT = 8'h5A;
	localparam logic [7:0] PASS_TCS = 8'hA5;
	localparam logic [7:0] CLEAR_DATA = 8'h00;
	// field positions
	localparam int OVERFLOW_BIT = 7;
	localparam int MODE_BIT = 6;
	localparam int ENA_BIT = 5;
	localparam int WRF_BIT = 7;
	localparam int ROE_BIT = 6;
	localparam logic [1:0] TCS_RSVD = 2'h3;
	localparam logic [5:0] RCS_RSVD = 6'h3F;
	localparam logic [7:0] CNT_RESET = 8'h00;
	localparam logic [2:0] CKS_RESET = 3'h0;
	// timing, in states (one state = one system clock)
	localparam int INT_RESET_STATES = 518;
	localparam int EXT_RESET_STATES = 132;
	localparam int PRESCALE_W = 12;
endpackage : watchdog_pkg
`default_nettype wire

// >>> testbench/cpu_bus_model.sv
`default_nettype none
module cpu_bus_model (
	input wire logic i_sys_clk,
	input wire logic [7:0] i_rdata,
	output logic [19:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic o_word,
	output logic [15:0] o_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_addr, o_rd, o_wr, o_word, o_wdata} = '0;
	// held across the sampling edge, released a half cycle later
	task automatic wr(input logic [19:0] a, input logic [15:0] d,
		input logic w);
		@(negedge i_sys_clk);
		o_addr = a;
		o_wdata = d;
		o_word = w;
		o_wr = 1'b1;
		@(negedge i_sys_clk);
		o_wr = 1'b0;
		o_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [19:0] a, output logic [7:0] v);
		@(negedge i_sys_clk);
		o_addr = a;
		o_rd = 1'b1;
		@(negedge i_sys_clk);
		o_rd = 1'b0;
		v = i_rdata;
	endtask : rd
endmodule : cpu_bus_model
`default_nettype wire

// >>> testbench/tb_watchdog_interval_timer.sv
`default_nettype none
module tb_watchdog_interval_timer;
	import watchdog_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_sys_clk = 1'b0;
	logic i_srst = 1'b1;
	logic [19:0] i_addr;
	logic i_rd, i_wr, i_word;
	logic [15:0] i_wdata;
	logic [7:0] o_rdata;
	logic o_interval_interrupt, o_internal_reset, o_reset_output_pin_n;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	watchdog_interval_timer #(
		.INT_RESET_LEN(10),
		.EXT_RESET_LEN(4)
	) dut (
		.i_sys_clk(i_sys_clk),
		.i_srst(i_srst),
		.i_addr(i_addr),
		.i_rd(i_rd),
		.i_wr(i_wr),
		.i_word(i_word),
		.i_wdata(i_wdata),
		.o_rdata(o_rdata),
		.o_interval_interrupt(o_interval_interrupt),
		.o_internal_reset(o_internal_reset),
		.o_reset_output_pin_n(o_reset_output_pin_n)
	);
	cpu_bus_model cpu (.i_sys_clk(i_sys_clk), .i_rdata(o_rdata),
		.o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_word(i_word),
		.o_wdata(i_wdata));
	initial forever #5 i_sys_clk = ~i_sys_clk;
	task automatic check(input string nm, input logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic rdc(input string nm, input logic [19:0] a,
		input logic [7:0] e);
		logic [7:0] v;
		cpu.rd(a, v);
		check(nm, v, e);
	endtask : rdc
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task automatic t_protect;
		cpu.wr(TCS_ADDR, 16'hA5_27, 1'b1);
		rdc("tcs", TCS_ADDR, 8'h3F);
		cpu.wr(TCS_ADDR, 16'hA5_00, 1'b0);
		rdc("tcs", TCS_ADDR, 8'h3F);
		cpu.wr(TCS_ADDR, 16'h5B_00, 1'b1);
		rdc("tcs", TCS_ADDR, 8'h3F);
		cpu.wr(TCS_ADDR, 16'h5A_80, 1'b1);
		rdc("count", CNT_ADDR, 8'h80);
		cpu.wr(RCS_WR_ADDR, 16'h5A_FF, 1'b0);
		rdc("rcs", RCS_RD_ADDR, 8'h3F);
		cpu.wr(TCS_ADDR, 16'hA5_07, 1'b1);
		rdc("count", CNT_ADDR, 8'h00);
		$display("t_protect done");
	endtask : t_protect
	task automatic t_interval;
		cpu.wr(TCS_ADDR, 16'hA5_20, 1'b1);
		cpu.wr(TCS_ADDR, 16'h5A_F0, 1'b1);
		repeat (100)
			if (o_interval_interrupt !== 1'b1) @(negedge i_sys_clk);
		check("irq", {7'h0, o_interval_interrupt}, 8'h01);
		cpu.wr(TCS_ADDR, 16'hA5_20, 1'b1);
		check("irq", {7'h0, o_interval_interrupt}, 8'h01);
		rdc("tcs", TCS_ADDR, 8'hB8);
		rdc("rcs", RCS_RD_ADDR, 8'h3F);
		cpu.wr(TCS_ADDR, 16'hA5_38, 1'b1);
		check("irq", {7'h0, o_interval_interrupt}, 8'h00);
		cpu.wr(TCS_ADDR, 16'hA5_00, 1'b1);
		$display("t_interval done");
	endtask : t_interval
	task automatic t_watchdog;
		cpu.wr(RCS_WR_ADDR, 16'h5A_40, 1'b1);
		rdc("rcs", RCS_RD_ADDR, 8'h7F);
		cpu.wr(TCS_ADDR, 16'hA5_60, 1'b1);
		cpu.wr(TCS_ADDR, 16'h5A_F8, 1'b1);
		repeat (100)
			if (o_internal_reset !== 1'b1) @(negedge i_sys_clk);
		check("pin", {7'h0, o_reset_output_pin_n}, 8'h00);
		repeat (20)
			if (o_internal_reset !== 1'b0) @(negedge i_sys_clk);
		rdc("rcs", RCS_RD_ADDR, 8'hFF);
		rdc("tcs", TCS_ADDR, 8'h18);
		cpu.wr(RCS_WR_ADDR, 16'hA5_00, 1'b1);
		rdc("rcs", RCS_RD_ADDR, 8'h7F);
		@(negedge i_sys_clk) i_srst = 1'b1;
		@(negedge i_sys_clk) i_srst = 1'b0;
		rdc("rcs", RCS_RD_ADDR, 8'h3F);
		$display("t_watchdog done");
	endtask : t_watchdog
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (20) @(negedge i_sys_clk);
		i_srst = 1'b0;
		rdc("tcs", TCS_ADDR, 8'h18);
		rdc("rcs", RCS_RD_ADDR, 8'h3F);
		rdc("gap", RCS_WR_ADDR, 8'h00);
		t_protect();
		t_interval();
		t_watchdog();
		report_and_stop();
	end
endmodule : tb_watchdog_interval_timer
bind watchdog_interval_timer watchdog_checker #(
	.INT_RESET_LEN(INT_RESET_LEN), .EXT_RESET_LEN(EXT_RESET_LEN)) chk (
	.i_sys_clk(i_sys_clk),
	.i_srst(i_srst),
	.i_addr(i_addr),
	.i_rd(i_rd),
	.o_rdata(o_rdata),
	.o_interval_interrupt(o_interval_interrupt),
	.o_internal_reset(o_internal_reset),
	.o_reset_output_pin_n(o_reset_output_pin_n));
`default_nettype wire

// >>> testbench/watchdog_checker.sv
`default_nettype none
module watchdog_checker
	import watchdog_pkg::*;
#(
	parameter int INT_RESET_LEN = 10,
	parameter int EXT_RESET_LEN = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [19:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_interval_interrupt,
	input wire logic o_internal_reset,
	input wire logic o_reset_output_pin_n
);
	int n_reg;
	int m_reg;
	always_ff @(posedge i_sys_clk) begin
		n_reg <= (i_srst || !o_internal_reset) ? 0 : n_reg + 1;
		m_reg <= (i_srst || o_reset_output_pin_n) ? 0 : m_reg + 1;
	end
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	int_len_a: assert property (
		$fell(o_internal_reset) |-> n_reg == INT_RESET_LEN)
		else $error("internal reset length");
	int_max_a: assert property (
		o_internal_reset |-> n_reg < INT_RESET_LEN)
		else $error("internal reset too long");
	ext_len_a: assert property (
		$rose(o_reset_output_pin_n) |-> m_reg == EXT_RESET_LEN)
		else $error("reset pin length");
	ext_max_a: assert property (
		!o_reset_output_pin_n |-> m_reg < EXT_RESET_LEN)
		else $error("reset pin too long");
	pin_start_a: assert property (
		$fell(o_reset_output_pin_n) |-> $rose(o_internal_reset))
		else $error("reset pin without overflow");
	rdata_hold_a: assert property (
		!i_rd |=> $stable(o_rdata))
		else $error("read data moved");
	unmapped_a: assert property (
		i_rd && i_addr == RCS_WR_ADDR |=> o_rdata == 8'h00)
		else $error("write-only address read");
	rcs_ones_a: assert property (
		i_rd && i_addr == RCS_RD_ADDR |=> o_rdata[5:0] == RCS_RSVD)
		else $error("reserved bits not one");
	cover property ($rose(o_internal_reset));
	cover property ($rose(o_interval_interrupt));
	cover property ($fell(o_reset_output_pin_n));
endmodule : watchdog_checker
`default_nettype wire
